// ---- hdl/slkp_pkg.sv ----
// Constants and types of the status LED and keypad panel
//
// Behaviour
// - Power LED steady when supplied and ready
// - Power LED flashes while link is established
// - Output 1 LED follows switching output 1
// - Output 2 LED: output 2, or in-scale in analog role
// - Teach-in running: both output LEDs flash together
// - Teach fail 5 s alternate; fault alternates
// - Confirm opens, accepts, descends; cursor right
// - Cancel goes up a level; cursor left
// - Up steps screen; increments digit
// - Down steps screen; decrements digit
// - Hold up and down >3 s toggles lock
// - Padlock symbol shown while locked
// - Software command sets or clears lock
// - Line 1 is switch output or link
// - Line 2 analog, switch 2 or inverted
`default_nettype none
package slkp_pkg;
   // ****************************************************************
   // Timing
   // ****************************************************************
   localparam int CLK_HZ = 100_000_000;
   localparam int LOCK_HOLD_MS = 3000;
   localparam int TEACH_FAIL_MS = 5000;
   localparam int FLASH_HALF_MS = 250;
   localparam int LOCK_HOLD_CYC = LOCK_HOLD_MS * (CLK_HZ / 1000);
   localparam int TEACH_FAIL_CYC = TEACH_FAIL_MS * (CLK_HZ / 1000);
   localparam int FLASH_HALF_CYC = FLASH_HALF_MS * (CLK_HZ / 1000);
   // ****************************************************************
   // Register offsets
   // ****************************************************************
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_OUTS = 8'h04;
   localparam logic [7:0] OFS_TEACH = 8'h08;
   localparam logic [7:0] OFS_NEARFAR = 8'h0c;
   localparam logic [7:0] OFS_LOCK = 8'h10;
   localparam logic [7:0] OFS_PANEL = 8'h14;
   localparam logic [7:0] OFS_VALUE = 8'h18;
   localparam logic [7:0] OFS_ISTAT = 8'h1c;
   localparam logic [7:0] OFS_IMASK = 8'h20;
   // ****************************************************************
   // Field positions
   // ****************************************************************
   localparam int CTRL_READY = 0;
   localparam int CTRL_LINK = 1;
   localparam int CTRL_Q1LINK = 2;
   localparam int CTRL_Q2ROLE = 3;
   localparam int CTRL_FAULT = 5;
   localparam int OUTS_SW1 = 0;
   localparam int OUTS_SW2 = 1;
   localparam int OUTS_INSCALE = 2;
   localparam int TEACH_BUSY = 0;
   localparam int TEACH_MEASOK = 1;
   localparam int TEACH_DONE = 2;
   localparam int LOCK_SET = 0;
   localparam int LOCK_CLR = 1;
   localparam int IRQ_KEY = 0;
   localparam int IRQ_LOCK = 1;
   localparam int IRQ_TEACHFAIL = 2;
   localparam int IRQ_FAULT = 3;
   localparam int IRQ_BITS = 4;
   // ****************************************************************
   // Reset values and panel sizes
   // ****************************************************************
   localparam logic [5:0] CTRL_RESET = 6'h00;
   localparam logic [3:0] IMASK_RESET = 4'h0;
   localparam int NUM_BTN = 4;
   localparam int BTN_OK = 0;
   localparam int BTN_ESC = 1;
   localparam int BTN_UP = 2;
   localparam int BTN_DN = 3;
   localparam int MENU_LEVELS = 3;
   localparam int MENU_SCREENS = 4;
   localparam int NUM_DIGITS = 4;
   typedef enum logic [1:0] {Q2_ANALOG, Q2_SWITCH, Q2_INV_Q1} slkp_q2role_e;
endpackage : slkp_pkg
`default_nettype wire

// ---- hdl/slkp_btn_if.sv ----
// Debounced button levels and press pulses between panel modules
`default_nettype none
interface slkp_btn_if #(parameter int N = 4);
   logic [N-1:0] level;
   logic [N-1:0] press;
   modport src (output level, press);
   modport dst (input level, press);
endinterface : slkp_btn_if
`default_nettype wire

// ---- hdl/slkp_btn_sync.sv ----
// Button synchroniser with agreement filter and press pulses
`default_nettype none
module slkp_btn_sync
   import slkp_pkg::*;
#(
   parameter int N = NUM_BTN
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Button pins, high while pressed
   input wire logic [N-1:0] btnPin,
   // Filtered buttons
   slkp_btn_if.src btn
);
   typedef struct packed {
      logic [N-1:0] s1;
      logic [N-1:0] s2;
      logic [N-1:0] s3;
      logic [N-1:0] level;
      logic [N-1:0] press;
   } slkp_sync_s;

   slkp_sync_s st_r;
   slkp_sync_s st_nxt;

   always_comb begin
      st_nxt = st_r;
      st_nxt.s1 = btnPin;
      st_nxt.s2 = st_r.s1;
      st_nxt.s3 = st_r.s2;
      // A change counts once stages two and three agree
      for (int i = 0; i < N; i++) begin
         if (st_r.s2[i] == st_r.s3[i]) begin
            st_nxt.level[i] = st_r.s3[i];
         end
      end
      st_nxt.press = st_nxt.level & ~st_r.level;
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign btn.level = st_r.level;
   assign btn.press = st_r.press;
endmodule // slkp_btn_sync
`default_nettype wire

// ---- hdl/slkp_flash.sv ----
// Flash phase generator for the indicator LEDs
`default_nettype none
module slkp_flash
   import slkp_pkg::*;
#(
   parameter int HALF_CYC = FLASH_HALF_CYC
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Square wave, HALF_CYC cycles per half
   output logic phase
);
   typedef struct packed {
      logic [31:0] cnt;
      logic phase;
   } slkp_flash_s;

   slkp_flash_s st_r;
   slkp_flash_s st_nxt;

   always_comb begin
      st_nxt = st_r;
      if (st_r.cnt == 32'(HALF_CYC - 1)) begin
         st_nxt.cnt = '0;
         st_nxt.phase = ~st_r.phase;
      end else begin
         st_nxt.cnt = st_r.cnt + 32'h1;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign phase = st_r.phase;
endmodule // slkp_flash
`default_nettype wire

// ---- hdl/slkp_panel.sv ----
// Front panel: indicator LEDs, keypad menu, keypad lock, APB registers
//
// Chosen here: the placing of the registers and the APB interface to the registers.
`default_nettype none
module slkp_panel
   import slkp_pkg::*;
#(
   parameter int HOLD_CYC = LOCK_HOLD_CYC,
   parameter int FAIL_CYC = TEACH_FAIL_CYC,
   parameter int HALF_CYC = FLASH_HALF_CYC
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Buttons: confirm, cancel, up, down; high while pressed
   input wire logic [NUM_BTN-1:0] btnPin,
   // Link transceiver on output line 1
   input wire logic ioLinkTx,
   input wire logic ioLinkTxEn,
   input wire logic swOutPrimaryIn,
   // Output lines
   output logic swOutPrimary,
   output logic swOutPrimaryOe_n,
   output logic swOutSecondary,
   output logic analogOutputEn,
   // Indicators
   output logic powerIndicator,
   output logic ledOut1,
   output logic ledOut2,
   output logic padlockOn,
   // Interrupt
   output logic irq
);
   // ****************************************************************
   // State
   // ****************************************************************
   typedef struct packed {
      logic [5:0] ctrl;
      logic [2:0] outs;
      logic [1:0] teach;
      logic [15:0] nearVal;
      logic [15:0] farVal;
      logic locked;
      logic [31:0] holdCnt;
      logic holdDone;
      logic [31:0] failCnt;
      logic [1:0] level;
      logic [1:0] screen;
      logic numEntry;
      logic [1:0] cursor;
      logic [15:0] digits;
      logic [IRQ_BITS-1:0] istat;
      logic [IRQ_BITS-1:0] imask;
      logic [31:0] rdData;
      logic [4:0] leds;
      logic [2:0] lines;
   } slkp_panel_s;

   slkp_panel_s st_r;
   slkp_panel_s st_nxt;

   slkp_btn_if #(.N(NUM_BTN)) btn ();
   logic phase;

   slkp_btn_sync #(.N(NUM_BTN)) slkp_btn_sync_inst (
      .clk(clk),
      .reset_n(reset_n),
      .btnPin(btnPin),
      .btn(btn)
   );

   slkp_flash #(.HALF_CYC(HALF_CYC)) slkp_flash_inst (
      .clk(clk),
      .reset_n(reset_n),
      .phase(phase)
   );

   // ****************************************************************
   // Helpers
   // ****************************************************************
   function automatic logic [3:0] digitStep(input logic [3:0] d, input logic up);
      logic [3:0] r;
      r = d;
      if (up) begin
         r = (d >= 4'h9) ? 4'h0 : d + 4'h1;
      end else begin
         r = (d == 4'h0 || d > 4'h9) ? 4'h9 : d - 4'h1;
      end
      return r;
   endfunction

   function automatic logic isMapped(input logic [7:0] a);
      return a == OFS_CTRL || a == OFS_OUTS || a == OFS_TEACH ||
         a == OFS_NEARFAR || a == OFS_LOCK || a == OFS_PANEL ||
         a == OFS_VALUE || a == OFS_ISTAT || a == OFS_IMASK;
   endfunction

   logic setupPh;
   logic wrAcc;
   logic rdAcc;
   assign setupPh = psel && !penable;
   assign wrAcc = psel && penable && pwrite && isMapped(paddr);
   assign rdAcc = psel && penable && !pwrite;

   // ****************************************************************
   // Next state
   // ****************************************************************
   always_comb begin
      logic [IRQ_BITS-1:0] ev;
      logic chord;
      logic teachFail;
      logic [3:0] dsel;
      logic failShow;
      logic flt;
      logic [1:0] role;
      ev = '0;
      chord = btn.level[BTN_UP] && btn.level[BTN_DN];
      teachFail = 1'b0;
      dsel = 4'h0;
      failShow = 1'b0;
      flt = 1'b0;
      role = 2'h0;
      st_nxt = st_r;

      // Register writes in the access phase
      if (wrAcc) begin
         unique case (paddr)
            OFS_CTRL: begin
               st_nxt.ctrl = pwdata[5:0];
               if (pwdata[CTRL_FAULT] && !st_r.ctrl[CTRL_FAULT]) begin
                  ev[IRQ_FAULT] = 1'b1;
               end
            end
            OFS_OUTS: st_nxt.outs = pwdata[2:0];
            OFS_TEACH: begin
               st_nxt.teach = pwdata[1:0];
               if (pwdata[TEACH_DONE]) begin
                  teachFail = !pwdata[TEACH_MEASOK] || st_r.nearVal == st_r.farVal;
               end
            end
            OFS_NEARFAR: begin
               st_nxt.nearVal = pwdata[15:0];
               st_nxt.farVal = pwdata[31:16];
            end
            OFS_IMASK: st_nxt.imask = pwdata[IRQ_BITS-1:0];
            default: ;
         endcase
      end

      if (teachFail) begin
         st_nxt.failCnt = 32'(FAIL_CYC);
         ev[IRQ_TEACHFAIL] = 1'b1;
      end else if (st_r.failCnt != 32'h0) begin
         st_nxt.failCnt = st_r.failCnt - 32'h1;
      end

      if (chord) begin
         if (!st_r.holdDone) begin
            if (st_r.holdCnt == 32'(HOLD_CYC)) begin
               st_nxt.holdDone = 1'b1;
               st_nxt.locked = ~st_r.locked;
               ev[IRQ_LOCK] = 1'b1;
            end else begin
               st_nxt.holdCnt = st_r.holdCnt + 32'h1;
            end
         end
      end else begin
         st_nxt.holdCnt = '0;
         st_nxt.holdDone = 1'b0;
      end

      if (wrAcc && paddr == OFS_LOCK) begin
         if (pwdata[LOCK_SET]) begin
            st_nxt.locked = 1'b1;
         end else if (pwdata[LOCK_CLR]) begin
            st_nxt.locked = 1'b0;
         end
      end

      // Navigation only while unlocked and no chord
      dsel = st_r.digits[{st_r.cursor, 2'b00} +: 4];
      if (!st_r.locked && !chord) begin
         if (btn.press[BTN_OK]) begin
            ev[IRQ_KEY] = 1'b1;
            if (st_r.numEntry) begin
               if (st_r.cursor == 2'(NUM_DIGITS - 1)) begin
                  st_nxt.numEntry = 1'b0;
               end else begin
                  st_nxt.cursor = st_r.cursor + 2'h1;
               end
            end else if (st_r.level < 2'(MENU_LEVELS - 1)) begin
               st_nxt.level = st_r.level + 2'h1;
               st_nxt.screen = '0;
            end else begin
               st_nxt.numEntry = 1'b1;
               st_nxt.cursor = '0;
            end
         end else if (btn.press[BTN_ESC]) begin
            ev[IRQ_KEY] = 1'b1;
            if (st_r.numEntry) begin
               if (st_r.cursor == 2'h0) begin
                  st_nxt.numEntry = 1'b0;
               end else begin
                  st_nxt.cursor = st_r.cursor - 2'h1;
               end
            end else if (st_r.level != 2'h0) begin
               st_nxt.level = st_r.level - 2'h1;
               st_nxt.screen = '0;
            end
         end else if (btn.press[BTN_UP]) begin
            ev[IRQ_KEY] = 1'b1;
            if (st_r.numEntry) begin
               st_nxt.digits[{st_r.cursor, 2'b00} +: 4] = digitStep(dsel, 1'b1);
            end else begin
               st_nxt.screen = st_r.screen + 2'h1;
            end
         end else if (btn.press[BTN_DN]) begin
            ev[IRQ_KEY] = 1'b1;
            if (st_r.numEntry) begin
               st_nxt.digits[{st_r.cursor, 2'b00} +: 4] = digitStep(dsel, 1'b0);
            end else begin
               st_nxt.screen = st_r.screen - 2'h1;
            end
         end
      end

      // Read data captured in setup, so the reported bits are the ones cleared
      if (setupPh) begin
         unique case (paddr)
            OFS_CTRL: st_nxt.rdData = 32'(st_r.ctrl);
            OFS_OUTS: st_nxt.rdData = 32'(st_r.outs);
            OFS_TEACH: st_nxt.rdData = 32'(st_r.teach);
            OFS_NEARFAR: st_nxt.rdData = {st_r.farVal, st_r.nearVal};
            OFS_LOCK: st_nxt.rdData = 32'(st_r.locked);
            OFS_PANEL: st_nxt.rdData = 32'({swOutPrimaryIn, st_r.failCnt != 32'h0,
               st_r.cursor, st_r.numEntry, st_r.screen, st_r.level});
            OFS_VALUE: st_nxt.rdData = 32'(st_r.digits);
            OFS_ISTAT: st_nxt.rdData = 32'(st_r.istat);
            OFS_IMASK: st_nxt.rdData = 32'(st_r.imask);
            default: st_nxt.rdData = '0;
         endcase
      end

      // Read clears reported bits; a new event wins
      st_nxt.istat = st_r.istat | ev;
      if (rdAcc && paddr == OFS_ISTAT) begin
         st_nxt.istat = (st_r.istat & ~st_r.rdData[IRQ_BITS-1:0]) | ev;
      end

      // ************************************************************
      // Indicators
      // ************************************************************
      failShow = st_r.failCnt != 32'h0;
      flt = st_r.ctrl[CTRL_FAULT];
      // Power steady / dark, flashes on link
      st_nxt.leds[0] = st_r.ctrl[CTRL_READY] && (!st_r.ctrl[CTRL_LINK] || phase);
      if (st_r.teach[TEACH_BUSY]) begin
         st_nxt.leds[1] = phase;
         st_nxt.leds[2] = phase;
      end else if (failShow || flt) begin
         st_nxt.leds[1] = phase;
         st_nxt.leds[2] = ~phase;
      end else begin
         st_nxt.leds[1] = st_r.outs[OUTS_SW1];
         st_nxt.leds[2] = st_r.outs[OUTS_SW2] ||
            (st_r.ctrl[CTRL_Q2ROLE +: 2] == 2'(Q2_ANALOG) && st_r.outs[OUTS_INSCALE]);
      end
      st_nxt.leds[3] = st_nxt.locked;
      st_nxt.leds[4] = |(st_r.istat & st_r.imask);

      // ************************************************************
      // Output lines
      // ************************************************************
      // Line 1 role select
      if (st_r.ctrl[CTRL_Q1LINK]) begin
         st_nxt.lines[0] = ioLinkTx;
         st_nxt.leds[4] = st_nxt.leds[4];
      end else begin
         st_nxt.lines[0] = st_r.outs[OUTS_SW1];
      end
      // Line 2 role select; unused code behaves as analog
      role = st_r.ctrl[CTRL_Q2ROLE +: 2];
      if (role == 2'(Q2_SWITCH)) begin
         st_nxt.lines[1] = st_r.outs[OUTS_SW2];
         st_nxt.lines[2] = 1'b0;
      end else if (role == 2'(Q2_INV_Q1)) begin
         st_nxt.lines[1] = ~st_r.outs[OUTS_SW1];
         st_nxt.lines[2] = 1'b0;
      end else begin
         st_nxt.lines[1] = 1'b0;
         st_nxt.lines[2] = 1'b1;
      end
   end

   // ****************************************************************
   // Registers
   // ****************************************************************
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         st_r <= '0;
         st_r.ctrl <= CTRL_RESET;
         st_r.imask <= IMASK_RESET;
         st_r.lines[2] <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   assign prdata = st_r.rdData;
   assign pready = psel && penable;
   assign pslverr = psel && penable && !isMapped(paddr);
   assign swOutPrimary = st_r.lines[0];
   // Push-pull always drives; in link role the transceiver releases it
   assign swOutPrimaryOe_n = st_r.ctrl[CTRL_Q1LINK] && !ioLinkTxEn;
   assign swOutSecondary = st_r.lines[1];
   assign analogOutputEn = st_r.lines[2];
   assign powerIndicator = st_r.leds[0];
   assign ledOut1 = st_r.leds[1];
   assign ledOut2 = st_r.leds[2];
   assign padlockOn = st_r.leds[3];
   assign irq = st_r.leds[4];
endmodule // slkp_panel
`default_nettype wire

// ---- tb/slkp_panel_asserts.sv ----
// Port checks of the front panel
`default_nettype none
module slkp_panel_asserts
   import slkp_pkg::*;
#(
   parameter int HOLD_CYC = LOCK_HOLD_CYC
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic pslverr,
   // Pins
   input wire logic [NUM_BTN-1:0] btnPin,
   input wire logic ioLinkTx,
   input wire logic ioLinkTxEn,
   input wire logic swOutPrimary,
   input wire logic swOutPrimaryOe_n,
   input wire logic padlockOn,
   input wire logic irq
);
   timeunit 1ns;
   timeprecision 100ps;
   int holdCnt;
   logic lockWr, chordPin, chordWas;
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   assign lockWr = psel && penable && pwrite && paddr == OFS_LOCK;
   assign chordPin = btnPin[BTN_UP] && btnPin[BTN_DN];
   // Length of the latest lock chord at the pins, kept after release
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         holdCnt <= 0;
         chordWas <= 1'b0;
      end else begin
         chordWas <= chordPin;
         holdCnt <= !chordPin ? holdCnt : chordWas ? holdCnt + 1 : 1;
      end
   end
   // ****
   // Assertions
   // ****
   chk_lock_set_show: assert property (lockWr && pwdata[LOCK_SET] |=> padlockOn)
      else $error("padlock missing after lock set");
   chk_lock_clr_hide: assert property (lockWr && pwdata[1:0] == 2'b10 |=> !padlockOn)
      else $error("padlock still shown after lock clear");
   chk_lock_hold_only: assert property ($changed(padlockOn) && !$past(lockWr) |-> holdCnt >= HOLD_CYC)
      else $error("lock toggled without a full chord hold");
   chk_link_oe_drive: assert property (swOutPrimaryOe_n |-> !ioLinkTxEn)
      else $error("line 1 released while link transmits");
   chk_link_data_pass: assert property (swOutPrimaryOe_n && $past(swOutPrimaryOe_n) |-> swOutPrimary == $past(ioLinkTx))
      else $error("line 1 does not carry link data");
   chk_apb_zero_wait: assert property (psel && penable |-> pready)
      else $error("access phase without ready");
   chk_unmapped_err: assert property (psel && penable && paddr > OFS_IMASK |-> pslverr)
      else $error("unmapped access without error");
   chk_mask_quiet: assert property (psel && penable && pwrite && paddr == OFS_IMASK && pwdata[3:0] == 4'h0 |=> ##1 !irq)
      else $error("interrupt high with all events masked");
   cover property ($rose(padlockOn) && !$past(lockWr));
   cover property (swOutPrimaryOe_n);
   cover property ($rose(irq));
endmodule : slkp_panel_asserts
bind slkp_panel slkp_panel_asserts #(.HOLD_CYC(HOLD_CYC)) slkp_panel_asserts_inst (
   .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .btnPin(btnPin),
   .ioLinkTx(ioLinkTx), .ioLinkTxEn(ioLinkTxEn), .swOutPrimary(swOutPrimary),
   .swOutPrimaryOe_n(swOutPrimaryOe_n), .padlockOn(padlockOn), .irq(irq));
`default_nettype wire

// ---- tb/slkp_operator.sv ----
// Operator model pressing the panel buttons
`default_nettype none
module slkp_operator
   import slkp_pkg::*;
(
   // Clock
   input wire logic clk,
   // Buttons, high while pressed
   output var logic [NUM_BTN-1:0] btnPin
);
   timeunit 1ns;
   timeprecision 100ps;
   initial btnPin = '0;
   // One short press, then a pause for the filter to settle
   task automatic press(input int idx);
      btnPin[idx] <= 1'b1;
      repeat (8) @(posedge clk);
      btnPin[idx] <= 1'b0;
      repeat (10) @(posedge clk);
   endtask
   task automatic holdChord(input int n);
      btnPin[BTN_UP] <= 1'b1;
      btnPin[BTN_DN] <= 1'b1;
      repeat (n) @(posedge clk);
      btnPin <= '0;
      repeat (10) @(posedge clk);
   endtask
endmodule : slkp_operator
`default_nettype wire

// ---- tb/slkp_panel_test.sv ----
// Self-checking bench of the front panel
`default_nettype none
module slkp_panel_test
   import slkp_pkg::*;
();
   timeunit 1ns;
   timeprecision 100ps;
   localparam int HOLD = 20;
   localparam int FAIL = 30;
   logic clk, reset_n, psel, penable, pwrite, pready, pslverr, err;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [NUM_BTN-1:0] btnPin;
   logic ioLinkTx, ioLinkTxEn, swOutPrimaryIn, swOutPrimary, swOutPrimaryOe_n;
   logic swOutSecondary, analogOutputEn, powerIndicator, ledOut1, ledOut2, padlockOn, irq;
   logic [2:0] o;
   logic [1:0] e;
   int miscompares, check_count, seed, h1, hp, same, role;
   // Button sequence: 0 confirm, 1 cancel, 2 up, 3 down; panel view after each
   int btnSeq[13] = '{0, 0, 0, 2, 3, 3, 0, 1, 1, 1, 2, 3, 3};
   logic [6:0] panSeq[13] = '{7'h01, 7'h02, 7'h12, 7'h12, 7'h12, 7'h12, 7'h32, 7'h12,
      7'h02, 7'h01, 7'h05, 7'h01, 7'h0d};
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   slkp_panel #(.HOLD_CYC(HOLD), .FAIL_CYC(FAIL), .HALF_CYC(4)) slkp_panel_inst (
      .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .btnPin(btnPin), .ioLinkTx(ioLinkTx), .ioLinkTxEn(ioLinkTxEn),
      .swOutPrimaryIn(swOutPrimaryIn), .swOutPrimary(swOutPrimary),
      .swOutPrimaryOe_n(swOutPrimaryOe_n), .swOutSecondary(swOutSecondary),
      .analogOutputEn(analogOutputEn), .powerIndicator(powerIndicator), .ledOut1(ledOut1),
      .ledOut2(ledOut2), .padlockOn(padlockOn), .irq(irq));
   slkp_operator slkp_operator_inst (.clk(clk), .btnPin(btnPin));
   // ****
   // Tasks and expectations
   // ****
   // Indicator 2 and line 2 level for a role and output states
   function automatic logic [1:0] expOut2(input int r, input logic [2:0] s);
      return (r == 0) ? {s[1] | s[2], 1'b0} : {s[1], (r == 1) ? s[1] : !s[0]};
   endfunction
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic results();
      $display("checks %0d miscompares %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (n >= 16) begin
         miscompares++;
         results();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Let outputs settle, then count indicator states over n cycles
   task automatic sample(input int n);
      h1 = 0;
      hp = 0;
      same = 0;
      repeat (3) @(posedge clk);
      repeat (n) begin
         @(posedge clk);
         h1 += (ledOut1 === 1'b1);
         hp += (powerIndicator === 1'b1);
         same += (ledOut1 === ledOut2);
      end
   endtask
   // ****
   // Main sequence
   // ****
   initial begin
      seed = 32'h7158;
      miscompares = 0;
      check_count = 0;
      {reset_n, psel, penable, pwrite, ioLinkTx, ioLinkTxEn} = '0;
      paddr = 8'h00;
      pwdata = 32'h0;
      swOutPrimaryIn = 1'($random(seed));
      repeat (12) @(posedge clk);
      reset_n <= 1'b1;
      check("power off", powerIndicator, 32'h0);
      check("line2 analog", analogOutputEn, 32'h1);
      apb(1'b0, OFS_CTRL, 32'h0);
      check("ctrl reset", rd, 32'h0);
      apb(1'b1, OFS_CTRL, 32'h1);
      sample(16);
      check("power steady", hp, 32'h10);
      apb(1'b1, OFS_CTRL, 32'h3);
      sample(16);
      check("power flash", hp, 32'h8);
      $display("test power done");
      for (int i = 0; i < 9; i++) begin
         role = i % 3;
         o = 3'($random(seed));
         e = expOut2(role, o);
         apb(1'b1, OFS_CTRL, (32'(role) << 3) | 32'h1);
         apb(1'b1, OFS_OUTS, 32'(o));
         sample(1);
         check("led1", ledOut1, 32'(o[0]));
         check("line1", swOutPrimary, 32'(o[0]));
         check("analog en", analogOutputEn, 32'(role == 0));
         check("led2", ledOut2, 32'(e[1]));
         if (role != 0) begin
            check("line2", swOutSecondary, 32'(e[0]));
         end
      end
      apb(1'b1, OFS_CTRL, 32'h5);
      repeat (8) begin
         @(posedge clk);
         ioLinkTx <= 1'($random(seed));
         ioLinkTxEn <= 1'($random(seed));
         #1;
         check("line1 oe", swOutPrimaryOe_n, 32'(!ioLinkTxEn));
      end
      apb(1'b1, OFS_CTRL, 32'h1);
      apb(1'b1, OFS_OUTS, 32'h0);
      $display("test outputs done");
      apb(1'b1, OFS_TEACH, 32'h1);
      sample(16);
      check("teach flash", h1, 32'h8);
      check("teach phase", same, 32'h10);
      apb(1'b0, OFS_ISTAT, 32'h0);
      apb(1'b1, OFS_IMASK, 32'h4);
      apb(1'b1, OFS_TEACH, 32'h4);
      sample(16);
      check("fail flash", h1, 32'h8);
      check("fail alt", same, 32'h0);
      check("irq set", irq, 32'h1);
      apb(1'b0, OFS_PANEL, 32'h0);
      check("fail shown", rd[7], 32'h1);
      check("line readback", rd[8], 32'(swOutPrimaryIn));
      apb(1'b0, OFS_ISTAT, 32'h0);
      check("no measure", rd & 32'h4, 32'h4);
      sample(1);
      check("irq clear", irq, 32'h0);
      sample(FAIL);
      check("fail over", same, 32'(FAIL));
      for (int i = 0; i < 2; i++) begin
         rd = 32'($random(seed)) & 32'hffff;
         apb(1'b1, OFS_NEARFAR, (rd << 16) | (rd ^ 32'(i)));
         apb(1'b1, OFS_TEACH, 32'h6);
         apb(1'b0, OFS_ISTAT, 32'h0);
         check("near far", rd & 32'h4, (i == 0) ? 32'h4 : 32'h0);
      end
      apb(1'b1, OFS_IMASK, 32'h0);
      apb(1'b1, OFS_CTRL, 32'h21);
      sample(16);
      check("fault alt", same, 32'h0);
      apb(1'b1, OFS_CTRL, 32'h1);
      sample(8);
      check("fault end", same, 32'h8);
      $display("test teach done");
      for (int i = 0; i < 13; i++) begin
         slkp_operator_inst.press(btnSeq[i]);
         apb(1'b0, OFS_PANEL, 32'h0);
         check("panel", rd[6:0], 32'(panSeq[i]));
      end
      apb(1'b0, OFS_VALUE, 32'h0);
      check("digit", rd[3:0], 32'h9);
      $display("test buttons done");
      apb(1'b1, OFS_LOCK, 32'h1);
      sample(1);
      check("padlock", padlockOn, 32'h1);
      slkp_operator_inst.press(BTN_UP);
      apb(1'b0, OFS_PANEL, 32'h0);
      check("locked keys", rd[6:0], 32'h0d);
      apb(1'b1, OFS_LOCK, 32'h2);
      sample(1);
      check("unlock", padlockOn, 32'h0);
      slkp_operator_inst.holdChord(HOLD + 15);
      check("chord lock", padlockOn, 32'h1);
      apb(1'b0, OFS_LOCK, 32'h0);
      check("lock state", rd[0], 32'h1);
      slkp_operator_inst.holdChord(HOLD - 5);
      check("short hold", padlockOn, 32'h1);
      slkp_operator_inst.holdChord(HOLD + 15);
      check("chord unlock", padlockOn, 32'h0);
      apb(1'b0, 8'h40, 32'h0);
      check("unmapped err", err, 32'h1);
      check("unmapped data", rd, 32'h0);
      $display("test lock done");
      results();
   end
endmodule : slkp_panel_test
`default_nettype wire
